// *** hw/sac_defs.svh ***
// constants and functional notes of the serial converter control block
// Functional notes
// - din sampled on rising sclk while selected, up to the last control bit
// - bits ignored while chip select is high
// - dout changes on each falling sclk edge after the start bit
// - dout floats whenever chip select is high
// - internal mode: strobe low after eighth fall
// - external mode: strobe high one period before MSB
// - external strobe floats with cs high; internal driven
// - external mode: sclk paces acquisition and conversion
// - shutdown_n low forces full power-down always
// - mode codes: int, ext, standby, full power-down
// - acquisition from sixth fall, six clock cycles
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH

// control byte layout
`define SAC_SEL_HI 6
`define SAC_SEL_LO 4
`define SAC_RNG_BIT 3
`define SAC_BIP_BIT 2
`define SAC_PD_HI 1
`define SAC_PD_LO 0

// power and clock codes
`define SAC_PD_NORM_INT 2'h0
`define SAC_PD_NORM_EXT 2'h1
`define SAC_PD_STANDBY 2'h2
`define SAC_PD_FULL 2'h3

// serial clock numbers inside a frame, counted from the start bit
`define SAC_CLK_ACQ_START 5'h06
`define SAC_CLK_CTRL_DONE 5'h08
`define SAC_CLK_INT_LOAD 5'h09
`define SAC_CLK_EXT_HOLD 5'h0C
`define SAC_CLK_EXT_LOAD 5'h0D
`define SAC_CLK_MAX 5'h1F

// widths and counts
`define SAC_RESULT_W 12
`define SAC_FIFO_DEPTH 16
`define SAC_INT_ACQ_CYCLES 3'h4
`define SAC_SYNC_W 6

`endif

// *** hw/sac_pkg.sv ***
// types shared by the serial converter control block
package sac_pkg;

  typedef enum logic [1:0] {SAC_IDLE, SAC_ACQ_INT, SAC_WAIT_HOLD, SAC_WAIT_RESULT} sac_state_t;

  // rising-edge frame state, cleared by chip select high
  typedef struct packed {
    logic started;
    logic [4:0] clkNum;
    logic [7:0] shiftIn;
  } sac_rise_t;

  // falling-edge frame state, cleared by chip select high
  typedef struct packed {
    logic dout;
    logic extStrobe;
    logic [11:0] outShift;
  } sac_fall_t;

  // falling-edge state kept across frames
  typedef struct packed {
    logic extMode;
    logic [2:0] channel;
    logic rangeSel;
    logic polaritySel;
    logic [1:0] powerClockMode;
    logic acqTgl;
    logic reqTgl;
    logic holdTgl;
  } sac_keep_t;

  // system clock side
  typedef struct packed {
    sac_state_t state;
    logic [1:0] powerClockMode;
    logic extMode;
    logic [2:0] channel;
    logic rangeSel;
    logic polaritySel;
    logic [2:0] acqCnt;
    logic [2:0] tglSeen;
    logic trackHold;
    logic convStart;
    logic strobeInt;
    logic [11:0] resultWord;
    logic doutOe;
    logic strobeOut;
    logic strobeOe;
    logic fullPowerDown;
    logic standbyPowerDown;
  } sac_sys_t;

endpackage

// *** hw/sac_sync.sv ***
// three-flop synchroniser, output moves once the last two stages agree
module sac_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sac_sync_t;

  sac_sync_t r;
  sac_sync_t next_r;

  ////////////////////////////////////////////////////////////////
  // s1 only feeds s2, so no logic sees a metastable value
  always_comb
  begin
    next_r = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (r.s2[i] == r.s3[i])
      begin
        next_r.q[i] = r.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r <= {INIT, INIT, INIT, INIT};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign q = r.q;

endmodule

// *** hw/sac_fifo.sv ***
// result fifo with registered read data, valid and ready on both sides
module sac_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic ready;
    logic [WIDTH-1:0] rdData;
  } sac_fifo_t;

  sac_fifo_t r;
  sac_fifo_t next_r;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////
  // ready is kept as a flop of its own, so the source sees a registered level
  always_comb
  begin
    next_r = r;
    push = inValid && r.ready;
    pop = outReady && (r.count != '0);
    if (push)
    begin
      next_r.mem[r.wrPtr] = inData;
      next_r.wrPtr = r.wrPtr + 1'b1;
    end
    if (pop)
    begin
      next_r.rdPtr = r.rdPtr + 1'b1;
    end
    next_r.count = r.count + (AW + 1)'(push) - (AW + 1)'(pop);
    next_r.ready = (next_r.count != (AW + 1)'(DEPTH));
    // read ahead of the pointer, bypassing a write to the same slot
    next_r.rdData = next_r.mem[next_r.rdPtr];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r <= '{ready: 1'b1, default: '0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign inReady = r.ready;
  assign outValid = (r.count != '0);
  assign outData = r.rdData;

endmodule

// *** hw/sac_serial_adc_control.sv ***
// serial control and result interface of an eight-channel converter
`include "sac_defs.svh"

module sac_serial_adc_control
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic serialClk,
  input wire logic chipSelect_n,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutOe,
  output logic conversion_strobe,
  output logic conversionStrobeOe,
  input wire logic shutdown_n,
  output logic trackHold,
  output logic convStart,
  output logic [2:0] channel_select,
  output logic range_select,
  output logic polarity_select,
  output logic full_power_down,
  output logic standby_power_down,
  input wire logic convResultValid,
  output logic convResultReady,
  input wire logic [`SAC_RESULT_W-1:0] convResult
);

  sac_pkg::sac_rise_t rise;
  sac_pkg::sac_rise_t next_rise;
  sac_pkg::sac_fall_t fall;
  sac_pkg::sac_fall_t next_fall;
  sac_pkg::sac_keep_t keep;
  sac_pkg::sac_keep_t next_keep;
  sac_pkg::sac_sys_t s;
  sac_pkg::sac_sys_t next_s;
  logic frameRst_b;
  logic [7:0] ctrlByte;
  logic [`SAC_SYNC_W-1:0] syncIn;
  logic [`SAC_SYNC_W-1:0] syncQ;
  logic [2:0] tglEvt;
  logic extStrobeSync;
  logic csSync_n;
  logic shdnSync_n;
  logic fifoValid;
  logic fifoPop;
  logic [`SAC_RESULT_W-1:0] fifoData;
  logic fifoInReady;
  logic powerOk;

  // mode update shared by both clock domains
  function automatic logic ext_mode_of(input logic [1:0] code, input logic cur);
    if (code == `SAC_PD_NORM_EXT)
    begin
      return 1'b1;
    end
    if (code == `SAC_PD_NORM_INT)
    begin
      return 1'b0;
    end
    return cur;
  endfunction

  ////////////////////////////////////////////////////////////////
  // link domain: frame logic held in reset while not selected
  assign frameRst_b = rst_b && !chipSelect_n;

  // rising edges: wait for the start bit, then count and shift
  always_comb
  begin
    next_rise = rise;
    if (!rise.started)
    begin
      if (serialIn)
      begin
        next_rise.started = 1'b1;
        next_rise.clkNum = 5'h01;
        next_rise.shiftIn = {rise.shiftIn[6:0], serialIn};
      end
    end
    else
    begin
      if (rise.clkNum != `SAC_CLK_MAX)
      begin
        next_rise.clkNum = rise.clkNum + 5'h01;
      end
      if (rise.clkNum < `SAC_CLK_CTRL_DONE)
      begin
        next_rise.shiftIn = {rise.shiftIn[6:0], serialIn};
      end
    end
  end

  always_ff @(posedge serialClk or negedge frameRst_b)
  begin
    if (!frameRst_b)
    begin
      rise <= '0;
    end
    else
    begin
      rise <= next_rise;
    end
  end

  assign ctrlByte = rise.shiftIn;

  // falling edges inside the frame: strobe pulse and result shifting
  always_comb
  begin
    next_fall = fall;
    next_fall.extStrobe = 1'b0;
    if (rise.started)
    begin
      // one period high right before the MSB decision
      if (keep.extMode && rise.clkNum == `SAC_CLK_EXT_HOLD)
      begin
        next_fall.extStrobe = 1'b1;
      end
      if (rise.clkNum == (keep.extMode ? `SAC_CLK_EXT_LOAD : `SAC_CLK_INT_LOAD))
      begin
        next_fall.dout = s.resultWord[`SAC_RESULT_W-1];
        next_fall.outShift = {s.resultWord[`SAC_RESULT_W-2:0], 1'b0};
      end
      else
      begin
        next_fall.dout = fall.outShift[`SAC_RESULT_W-1];
        next_fall.outShift = {fall.outShift[`SAC_RESULT_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(negedge serialClk or negedge frameRst_b)
  begin
    if (!frameRst_b)
    begin
      fall <= '0;
    end
    else
    begin
      fall <= next_fall;
    end
  end

  // falling edges kept across frames: fields, clock mode, event toggles
  always_comb
  begin
    next_keep = keep;
    if (rise.started && rise.clkNum == `SAC_CLK_ACQ_START)
    begin
      next_keep.acqTgl = !keep.acqTgl;
    end
    if (rise.started && rise.clkNum == `SAC_CLK_CTRL_DONE)
    begin
      next_keep.channel = ctrlByte[`SAC_SEL_HI:`SAC_SEL_LO];
      next_keep.rangeSel = ctrlByte[`SAC_RNG_BIT];
      next_keep.polaritySel = ctrlByte[`SAC_BIP_BIT];
      next_keep.powerClockMode = ctrlByte[`SAC_PD_HI:`SAC_PD_LO];
      next_keep.extMode = ext_mode_of(ctrlByte[`SAC_PD_HI:`SAC_PD_LO], keep.extMode);
      next_keep.reqTgl = !keep.reqTgl;
    end
    // sclk decides the end of acquisition in external mode
    if (rise.started && keep.extMode && rise.clkNum == `SAC_CLK_EXT_HOLD)
    begin
      next_keep.holdTgl = !keep.holdTgl;
    end
  end

  // toggles must survive chip select, so only rst_b clears them
  always_ff @(negedge serialClk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      keep <= '0;
    end
    else
    begin
      keep <= next_keep;
    end
  end

  ////////////////////////////////////////////////////////////////
  // crossings into the system clock
  assign syncIn = {keep.acqTgl, keep.reqTgl, keep.holdTgl, fall.extStrobe, chipSelect_n, shutdown_n};

  sac_sync #(
    .WIDTH(`SAC_SYNC_W),
    .INIT(6'h03)
  ) u_sync (
    .clk(sys_clk),
    .rst_b(rst_b),
    .d(syncIn),
    .q(syncQ)
  );

  assign tglEvt = syncQ[5:3] ^ s.tglSeen;
  assign extStrobeSync = syncQ[2];
  assign csSync_n = syncQ[1];
  assign shdnSync_n = syncQ[0];

  ////////////////////////////////////////////////////////////////
  // results from the converter core wait here until presented
  sac_fifo #(
    .WIDTH(`SAC_RESULT_W),
    .DEPTH(`SAC_FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .rst_b(rst_b),
    .inValid(convResultValid),
    .inReady(fifoInReady),
    .inData(convResult),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  assign fifoPop = (s.state == sac_pkg::SAC_WAIT_RESULT);

  ////////////////////////////////////////////////////////////////
  // system side sequencer
  always_comb
  begin
    next_s = s;
    next_s.convStart = 1'b0;
    next_s.tglSeen = syncQ[5:3];
    powerOk = shdnSync_n && !s.powerClockMode[1];
    // acquisition begins on the sixth fall of the byte
    if (tglEvt[2] && powerOk)
    begin
      next_s.trackHold = 1'b1;
    end
    // fields were stable for many cycles before the toggle arrives
    if (tglEvt[1])
    begin
      next_s.channel = keep.channel;
      next_s.rangeSel = keep.rangeSel;
      next_s.polaritySel = keep.polaritySel;
      next_s.powerClockMode = keep.powerClockMode;
      next_s.extMode = ext_mode_of(keep.powerClockMode, s.extMode);
      if (!keep.powerClockMode[1] && shdnSync_n)
      begin
        next_s.acqCnt = 3'h0;
        if (ext_mode_of(keep.powerClockMode, s.extMode))
        begin
          next_s.state = sac_pkg::SAC_WAIT_HOLD;
        end
        else
        begin
          next_s.state = sac_pkg::SAC_ACQ_INT;
          next_s.strobeInt = 1'b0;
        end
      end
      else
      begin
        next_s.state = sac_pkg::SAC_IDLE;
        next_s.trackHold = 1'b0;
      end
    end
    else
    begin
      unique case (s.state)
        sac_pkg::SAC_IDLE:
        begin
        end
        sac_pkg::SAC_ACQ_INT:
        begin
          // two link clocks already spent, four internal ones follow
          next_s.acqCnt = s.acqCnt + 3'h1;
          if (next_s.acqCnt == `SAC_INT_ACQ_CYCLES)
          begin
            next_s.trackHold = 1'b0;
            next_s.convStart = 1'b1;
            next_s.state = sac_pkg::SAC_WAIT_RESULT;
          end
        end
        sac_pkg::SAC_WAIT_HOLD:
        begin
          if (tglEvt[0])
          begin
            next_s.trackHold = 1'b0;
            next_s.convStart = 1'b1;
            next_s.state = sac_pkg::SAC_WAIT_RESULT;
          end
        end
        sac_pkg::SAC_WAIT_RESULT:
        begin
          if (fifoValid)
          begin
            next_s.resultWord = fifoData;
            next_s.strobeInt = 1'b1;
            next_s.state = sac_pkg::SAC_IDLE;
          end
        end
      endcase
    end
    // the pin overrides whatever mode the byte selected
    if (!shdnSync_n)
    begin
      next_s.state = sac_pkg::SAC_IDLE;
      next_s.trackHold = 1'b0;
      next_s.strobeInt = 1'b1;
    end
    next_s.fullPowerDown = !shdnSync_n || (next_s.powerClockMode == `SAC_PD_FULL);
    next_s.standbyPowerDown = shdnSync_n && (next_s.powerClockMode == `SAC_PD_STANDBY);
    next_s.doutOe = !csSync_n;
    next_s.strobeOut = next_s.extMode ? extStrobeSync : next_s.strobeInt;
    next_s.strobeOe = next_s.extMode ? !csSync_n : 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s <= '{state: sac_pkg::SAC_IDLE, strobeInt: 1'b1, strobeOut: 1'b1, strobeOe: 1'b1, default: '0};
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs, all straight from flops
  assign serialOut = fall.dout;
  assign serialOutOe = s.doutOe;
  assign conversion_strobe = s.strobeOut;
  assign conversionStrobeOe = s.strobeOe;
  assign trackHold = s.trackHold;
  assign convStart = s.convStart;
  assign channel_select = s.channel;
  assign range_select = s.rangeSel;
  assign polarity_select = s.polaritySel;
  assign full_power_down = s.fullPowerDown;
  assign standby_power_down = s.standbyPowerDown;
  assign convResultReady = fifoInReady;

endmodule

// *** tb/sac_serial_adc_control_monitor.sv ***
// assertion checker watching the pins of the serial converter control block
module sac_serial_adc_control_monitor
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic chipSelect_n,
  input wire logic shutdown_n,
  input wire logic serialOutOe,
  input wire logic conversionStrobeOe,
  input wire logic trackHold,
  input wire logic convStart,
  input wire logic full_power_down,
  input wire logic standby_power_down
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////
  // seven samples leave room for the synchroniser and output flop
  sequence s_cs_idle;
    chipSelect_n [*7];
  endsequence
  sequence s_cs_busy;
    !chipSelect_n [*7];
  endsequence
  sequence s_shutdown_n_low;
    !shutdown_n [*7];
  endsequence

  ////////////////////////////////////////////////////////////
  a_dout_float: assert property (s_cs_idle |-> !serialOutOe)
    else $error("data output driven while deselected");
  a_dout_drive: assert property (s_cs_busy |-> serialOutOe)
    else $error("data output floating while selected");
  a_stb_float: assert property (!conversionStrobeOe |-> chipSelect_n || $past(chipSelect_n, 7))
    else $error("strobe floating while selected");
  a_stb_driven: assert property (s_cs_busy |-> conversionStrobeOe)
    else $error("strobe floating in a frame");
  a_shutdown_n_full: assert property (s_shutdown_n_low |-> full_power_down && !standby_power_down)
    else $error("shutdown not in full power-down");
  a_shutdown_n_quiet: assert property (s_shutdown_n_low |-> !convStart && !trackHold)
    else $error("activity during shutdown");
  a_pd_exclusive: assert property (standby_power_down |-> !full_power_down)
    else $error("both power-down outputs high");
  a_start_single: assert property (convStart |=> !convStart [*3])
    else $error("conversion start longer than one cycle");
  a_acq_in_frame: assert property ($rose(trackHold) |-> !chipSelect_n && shutdown_n)
    else $error("acquisition outside a frame");
endmodule

bind sac_serial_adc_control sac_serial_adc_control_monitor i_mon (.sys_clk(sys_clk), .rst_b(rst_b),
  .chipSelect_n(chipSelect_n), .shutdown_n(shutdown_n), .serialOutOe(serialOutOe),
  .conversionStrobeOe(conversionStrobeOe), .trackHold(trackHold), .convStart(convStart),
  .full_power_down(full_power_down), .standby_power_down(standby_power_down));

// *** tb/sac_host_model.sv ***
// host model: mode zero serial master for the converter link
module sac_host_model
(
  output logic serialClk,
  output logic chipSelect_n,
  output logic serialIn,
  input wire logic sdoWire,
  input wire logic stbWire
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HP = 62.5;
  logic [11:0] rxWord;
  logic sawLow;
  int nHigh;
  event done;

  ////////////////////////////////////////////////////////////
  // clock parked low, device deselected
  initial
  begin
    serialClk = 0;
    chipSelect_n = 1;
    serialIn = 1;
  end

  // one even-duty clock, data captured just before the rise
  task automatic clk(input bit grab);
    #HP;
    if (grab) rxWord = {rxWord[10:0], sdoWire};
    if (stbWire === 1'b1) nHigh++;
    serialClk = 1;
    #HP;
    serialClk = 0;
  endtask

  // kind: 0 internal, 1 external, 2 byte only, 3 clocks with cs high
  task automatic frame(input logic [7:0] ctrl, input int kind, input int pre);
    int k;
    int last;
    sawLow = 0;
    nHigh = 0;
    rxWord = '0;
    #3.3 chipSelect_n = kind == 3;
    #100;
    for (k = 0; k < pre + 8; k++)
    begin
      serialIn = (k < pre) ? 1'b0 : ctrl[7 - (k - pre)];
      clk(0);
    end
    // released data line shows the inverse, not a stale bit
    serialIn = ~serialIn;
    // strobe counted only after the byte: the old clock mode drives it before
    nHigh = 0;
    if (kind == 0)
    begin
      for (k = 0; k < 40 && stbWire !== 1'b0; k++) #1;
      sawLow = stbWire === 1'b0;
      for (k = 0; k < 4000 && stbWire !== 1'b1; k++) #5;
    end
    last = kind == 1 ? 25 : kind == 0 ? 21 : 8;
    for (k = 9; k <= last; k++) clk(k >= last - 11);
    #HP chipSelect_n = 1;
    if (kind < 2) ->done;
  endtask
endmodule

// *** tb/test_sac_serial_adc_control.sv ***
// self-checking bench of the serial converter control block
module test_sac_serial_adc_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0;
  logic rst_b = 0;
  logic shutdown_n = 1;
  logic convResultValid = 0;
  logic [11:0] convResult = '0;
  logic autoConv = 1;
  wire serialClk, chipSelect_n, serialIn, serialOut, serialOutOe, conversion_strobe, conversionStrobeOe;
  wire trackHold, convStart, range_select, polarity_select, full_power_down, standby_power_down;
  wire convResultReady;
  wire [2:0] channel_select;
  wire sdoWire = serialOutOe ? serialOut : 1'bz;
  wire stbWire = conversionStrobeOe ? conversion_strobe : 1'bz;
  int nMismatch = 0;
  int totalChecks = 0;
  logic [11:0] expQ[$];

  sac_serial_adc_control i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .serialClk(serialClk),
    .chipSelect_n(chipSelect_n), .serialIn(serialIn), .serialOut(serialOut), .serialOutOe(serialOutOe),
    .conversion_strobe(conversion_strobe), .conversionStrobeOe(conversionStrobeOe), .shutdown_n(shutdown_n),
    .trackHold(trackHold), .convStart(convStart), .channel_select(channel_select),
    .range_select(range_select), .polarity_select(polarity_select), .full_power_down(full_power_down),
    .standby_power_down(standby_power_down), .convResultValid(convResultValid),
    .convResultReady(convResultReady), .convResult(convResult));
  sac_host_model i_host (.serialClk(serialClk), .chipSelect_n(chipSelect_n), .serialIn(serialIn),
    .sdoWire(sdoWire), .stbWire(stbWire));

  ////////////////////////////////////////////////////////////
  initial forever #2.5 sys_clk = ~sys_clk;

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic waitSys(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic testDone;
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // converter stand-in: one word per start, queued as expected
  initial forever
  begin
    @(posedge sys_clk);
    if (autoConv && convStart === 1'b1)
    begin
      #1 convResultValid = 1;
      convResult = 12'($urandom);
      expQ.push_back(convResult);
      @(posedge sys_clk);
      while (convResultReady !== 1'b1) @(posedge sys_clk);
      #1 convResultValid = 0;
    end
  end

  // each word read by the host is matched against the oldest note
  initial forever
  begin
    @(i_host.done);
    check("result", i_host.rxWord, expQ.size() > 0 ? expQ.pop_front() : 'x);
  end

  // watchdog sized well above the expected run length
  initial
  begin
    #400000;
    nMismatch++;
    $display("mismatch watchdog expected finish seen hang");
    testDone();
  end

  ////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] ctrl;
    int n;
    void'($urandom(25));
    waitSys(2);
    check("dout enable", serialOutOe, 0);
    check("strobe", conversion_strobe, 1);
    check("fifo ready", convResultReady, 1);
    rst_b = 1;
    waitSys(12);
    $display("test reset done");
    // every power and clock code, leading zeros before the start bit
    for (n = 0; n < 4; n++)
    begin
      ctrl = {1'b1, 3'(n + 3), n[0], n[1], n[1:0]};
      i_host.frame(ctrl, n < 2 ? n : 2, n);
      waitSys(12);
      check("standby", standby_power_down, n == 2);
      check("full down", full_power_down, n == 3);
      check("channel", channel_select, ctrl[6:4]);
      check("range", range_select, ctrl[3]);
    end
    $display("test power codes done");
    for (n = 0; n < 12; n++)
    begin
      ctrl = {1'b1, 5'($urandom), 1'b0, n[0]};
      i_host.frame(ctrl, n[0], n % 3);
      if (n[0]) check("strobe periods", 12'(i_host.nHigh), 12'h001);
      else check("strobe low", i_host.sawLow, 1);
      check("polarity", polarity_select, ctrl[2]);
      // chip select stays high between frames
      waitSys(12);
    end
    waitSys(12);
    check("dout released", serialOutOe, 0);
    check("strobe released", conversionStrobeOe, 0);
    $display("test conversions done");
    i_host.frame(8'hFF, 3, 0);
    waitSys(12);
    check("full down", full_power_down, 0);
    check("channel kept", channel_select, ctrl[6:4]);
    $display("test deselected done");
    shutdown_n = 0;
    waitSys(10);
    check("shutdown", full_power_down, 1);
    i_host.frame(8'h81, 2, 0);
    waitSys(10);
    check("shutdown", full_power_down, 1);
    shutdown_n = 1;
    waitSys(10);
    check("wake", full_power_down, 0);
    $display("test shutdown done");
    // fill the result buffer until it refuses, then drain it
    autoConv = 0;
    convResultValid = 1;
    convResult = 12'($urandom);
    n = 0;
    repeat (20)
    begin
      @(posedge sys_clk);
      if (convResultReady === 1'b1)
      begin
        expQ.push_back(convResult);
        n++;
        #1 convResult = 12'($urandom);
      end
    end
    #1 convResultValid = 0;
    check("fifo words", 12'(n), 12'h010);
    repeat (16)
    begin
      i_host.frame(8'h80 | (8'($urandom) & 8'h7C), 0, 0);
      check("strobe low", i_host.sawLow, 1);
      waitSys(10 + $urandom % 40);
    end
    check("fifo ready", convResultReady, 1);
    check("queue left", 12'(expQ.size()), 12'h000);
    $display("test buffer done");
    testDone();
  end
endmodule
